//--- rtl/ilppg_defines.svh
// Contract
// - routing switch changes only on the master period match in interlocked mode; outside interlocked mode it is held at zero.
// - reversed order routes slave wave to first phase, master wave to second.
// - trailing edge inside master cycle gives clean outputs at a switch.
// - trailing edge past master cycle may give short extra pulses at a switch.
// - phase compare uses bits 16:1, below half period, interlocked only.
// - period is compare times clock; interlocked uses master clock and period.
// - master duty is second minus first against the remaining period.
// - compare-0 interrupt event chosen by each unit's two-bit source select.
// - master codes: none, period match, phase match, overflow unavailable.
// - slave codes: none, slave period match in independent only, else none.
// - four fixed edge compare interrupts per unit in both modes.
// - phase order select bit sets lead or lag in interlocked mode.
// - interlocked slave counter saturates at all ones until phase match.
`ifndef ILPPG_DEFINES_SVH
`define ILPPG_DEFINES_SVH
`define ILP_A_CTRL 4'h0
`define ILP_A_M_PER 4'h1
`define ILP_A_M_E1 4'h2
`define ILP_A_M_E2 4'h3
`define ILP_A_M_E3 4'h4
`define ILP_A_M_E4 4'h5
`define ILP_A_PHASE 4'h6
`define ILP_A_S_PER 4'h7
`define ILP_A_S_E1 4'h8
`define ILP_A_S_E2 4'h9
`define ILP_A_S_E3 4'hA
`define ILP_A_S_E4 4'hB
`define ILP_A_STAT 4'hC
`define ILP_A_IEN 4'hD
`define ILP_A_ICLR 4'hE
`define ILP_A_ROUTE 4'hF
`define ILP_B_RUN0 0
`define ILP_B_RUN1 1
`define ILP_B_ILOCK 2
`define ILP_B_PHORD 3
`define ILP_F_ISO0 5:4
`define ILP_F_ISO1 7:6
`define ILP_CTRL_W 8
`define ILP_NIRQ 10
`define ILP_CNT_MAX 16'hFFFF
`define ILP_CNT_ZERO 16'h0000
`define ILP_CNT_ONE 16'h0001
`define ILP_ISO_NONE 2'b00
`define ILP_ISO_PER 2'b01
`define ILP_ISO_PHASE 2'b10
`endif

//--- rtl/ilppg_pkg.sv
package ilppg_pkg;
  typedef enum logic [2:0] {
    ILP_IDLE_type_s = 3'b001,
    ILP_RUN_type_s = 3'b010,
    ILP_LOCK_type_s = 3'b100
  } ilp_mode_type;
  typedef logic [15:0] ilp_cnt_type;
endpackage

//--- rtl/ilppg_unit.sv
`timescale 1ns/1ns
`include "ilppg_defines.svh"
// one counter with period and four edge compares
module ilppg_unit (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // synced reset
  input wire logic run_i, // count enable
  input wire logic sat_i, // saturate instead of wrap
  input wire logic restart_i, // force count to zero
  input wire ilppg_pkg::ilp_cnt_type per_i, // period compare
  input wire ilppg_pkg::ilp_cnt_type e1_i, // first edge
  input wire ilppg_pkg::ilp_cnt_type e2_i, // second edge
  input wire ilppg_pkg::ilp_cnt_type e3_i, // third edge
  input wire ilppg_pkg::ilp_cnt_type e4_i, // fourth edge
  output ilppg_pkg::ilp_cnt_type cnt_o, // counter value
  output logic per_m_o, // period match pulse
  output logic [3:0] edge_m_o, // edge match pulses
  output logic wave_o // rectangular wave
);
  import ilppg_pkg::*;
  ilp_cnt_type cnt, next_cnt;
  logic wave, next_wave;
  logic [3:0] em;
  logic pm;
  assign cnt_o = cnt;
  assign em = {4{run_i}} & {cnt == e4_i, cnt == e3_i, cnt == e2_i, cnt == e1_i};
  assign pm = run_i && !sat_i && (cnt == per_i - `ILP_CNT_ONE);
  assign per_m_o = pm;
  assign edge_m_o = em;
  assign wave_o = wave;
  always_comb begin
    next_cnt = cnt;
    next_wave = wave;
    if (!run_i) begin
      next_cnt = `ILP_CNT_ZERO;
      next_wave = 1'b0;
    end else if (restart_i) begin
      next_cnt = `ILP_CNT_ZERO;
      next_wave = 1'b0;
    end else begin
      if (pm) begin
        next_cnt = `ILP_CNT_ZERO;
      end else if (cnt == `ILP_CNT_MAX) begin
        next_cnt = sat_i ? `ILP_CNT_MAX : `ILP_CNT_ZERO;
      end else begin
        next_cnt = cnt + `ILP_CNT_ONE;
      end
      // active from first edge to second edge
      if (em[0]) begin
        next_wave = 1'b1;
      end else if (em[1]) begin
        next_wave = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= `ILP_CNT_ZERO;
      wave <= 1'b0;
    end else begin
      cnt <= next_cnt;
      wave <= next_wave;
    end
  end
endmodule

//--- rtl/ilppg_top.sv
`timescale 1ns/1ns
`include "ilppg_defines.svh"
module ilppg_top (
  input wire logic CLK_I, // 100 MHz clock
  input wire logic RST_N_I, // async reset, active low
  input wire logic [5:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read strobe
  input wire logic AVS_WRITE_I, // write strobe
  input wire logic [31:0] AVS_WRITEDATA_I, // write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // byte enables
  output logic [31:0] AVS_READDATA_O, // read data
  output logic AVS_WAITREQUEST_O, // wait request
  output logic PHASE0_O, // first-phase output
  output logic PHASE1_O, // second-phase output
  output logic IRQ_O // level interrupt
);
  import ilppg_pkg::*;
  logic rs1, rs2;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rs2 <= rs1;
    end
  end
  logic [`ILP_CTRL_W-1:0] ctrl, next_ctrl;
  ilp_cnt_type cmp [0:10];
  ilp_cnt_type next_cmp [0:10];
  logic [16:0] phase, next_phase;
  logic [`ILP_NIRQ-1:0] stat, next_stat, ien, next_ien, ev;
  logic [31:0] rdata, next_rdata;
  logic wait_r, next_wait;
  logic route, next_route, p0, p1, next_p0, next_p1, irq, next_irq;
  logic m_pm, s_pm, ph_m, ilock, s_restart;
  logic [3:0] m_em, s_em;
  logic m_wave, s_wave;
  ilp_cnt_type m_cnt, s_cnt;
  logic [3:0] widx;
  logic wr_go, rd_go;
  assign widx = AVS_ADDRESS_I[5:2];
  // reads decode while waitrequest is high so their data stand registered;
  // writes land only at the edge that ends the cycle in which waitrequest is low
  assign wr_go = AVS_WRITE_I && !wait_r;
  assign rd_go = AVS_READ_I && wait_r;
  assign ilock = ctrl[`ILP_B_ILOCK];
  assign ph_m = ilock && ctrl[`ILP_B_RUN0] && (m_cnt == phase[16:1]);
  assign s_restart = ilock && ph_m;
  // in interlocked mode the slave period register is ignored
  ilppg_unit u_master (
    .clk_i(CLK_I),
    .rst_n_i(rs2),
    .run_i(ctrl[`ILP_B_RUN0]),
    .sat_i(1'b0),
    .restart_i(1'b0),
    .per_i(cmp[0]),
    .e1_i(cmp[1]),
    .e2_i(cmp[2]),
    .e3_i(cmp[3]),
    .e4_i(cmp[4]),
    .cnt_o(m_cnt),
    .per_m_o(m_pm),
    .edge_m_o(m_em),
    .wave_o(m_wave)
  );
  ilppg_unit u_slave (
    .clk_i(CLK_I),
    .rst_n_i(rs2),
    .run_i(ilock ? ctrl[`ILP_B_RUN0] : ctrl[`ILP_B_RUN1]),
    .sat_i(ilock),
    .restart_i(s_restart),
    .per_i(cmp[6]),
    .e1_i(cmp[7]),
    .e2_i(cmp[8]),
    .e3_i(cmp[9]),
    .e4_i(cmp[10]),
    .cnt_o(s_cnt),
    .per_m_o(s_pm),
    .edge_m_o(s_em),
    .wave_o(s_wave)
  );
  // compare-0 event selection per unit
  always_comb begin
    ev = '0;
    unique case (ctrl[`ILP_F_ISO0])
      `ILP_ISO_PER: ev[0] = m_pm;
      `ILP_ISO_PHASE: ev[0] = ph_m;
      default: ev[0] = 1'b0;
    endcase
    unique case (ctrl[`ILP_F_ISO1])
      `ILP_ISO_PER: ev[5] = s_pm && !ilock;
      default: ev[5] = 1'b0;
    endcase
    ev[4:1] = m_em;
    ev[9:6] = s_em;
  end
  always_comb begin
    next_ctrl = ctrl;
    next_phase = phase;
    next_ien = ien;
    next_wait = 1'b1;
    next_rdata = rdata;
    for (int i = 0; i < 11; i++) begin
      next_cmp[i] = cmp[i];
    end
    next_stat = stat;
    if (wr_go) begin
      unique case (widx)
        `ILP_A_CTRL: next_ctrl = AVS_WRITEDATA_I[`ILP_CTRL_W-1:0];
        `ILP_A_PHASE: next_phase = AVS_WRITEDATA_I[16:0];
        `ILP_A_IEN: next_ien = AVS_WRITEDATA_I[`ILP_NIRQ-1:0];
        `ILP_A_ICLR: next_stat = stat & ~AVS_WRITEDATA_I[`ILP_NIRQ-1:0];
        `ILP_A_STAT, `ILP_A_ROUTE: ;
        default: begin
          for (int i = 0; i < 11; i++) begin
            if (widx == 4'(i + 1) && i != 5) begin
              next_cmp[i] = AVS_WRITEDATA_I[15:0];
            end
          end
          if (widx == `ILP_A_S_PER) begin
            next_cmp[6] = AVS_WRITEDATA_I[15:0];
          end
        end
      endcase
    end
    next_stat = next_stat | ev; // set wins over clear
    if (rd_go) begin
      unique case (widx)
        `ILP_A_CTRL: next_rdata = {24'h00_0000, ctrl};
        `ILP_A_PHASE: next_rdata = {15'h0000, phase};
        `ILP_A_STAT: next_rdata = {22'h00_0000, stat};
        `ILP_A_IEN: next_rdata = {22'h00_0000, ien};
        `ILP_A_ICLR: next_rdata = 32'h0000_0000;
        `ILP_A_ROUTE: next_rdata = {31'h0000_0000, route};
        `ILP_A_M_PER: next_rdata = {16'h0000, cmp[0]};
        `ILP_A_M_E1: next_rdata = {16'h0000, cmp[1]};
        `ILP_A_M_E2: next_rdata = {16'h0000, cmp[2]};
        `ILP_A_M_E3: next_rdata = {16'h0000, cmp[3]};
        `ILP_A_M_E4: next_rdata = {16'h0000, cmp[4]};
        `ILP_A_S_PER: next_rdata = {16'h0000, cmp[6]};
        `ILP_A_S_E1: next_rdata = {16'h0000, cmp[7]};
        `ILP_A_S_E2: next_rdata = {16'h0000, cmp[8]};
        `ILP_A_S_E3: next_rdata = {16'h0000, cmp[9]};
        `ILP_A_S_E4: next_rdata = {16'h0000, cmp[10]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    // one low cycle per access, then high again whatever the master does
    if ((AVS_READ_I || AVS_WRITE_I) && wait_r) begin
      next_wait = 1'b0;
    end
  end
  // routing switch; a mismatch in levels at the switch instant is seen as a short
  // pulse, which software avoids by passing through in-phase first
  always_comb begin
    next_route = route;
    if (!ilock) begin
      next_route = 1'b0;
    end else if (m_pm) begin
      next_route = ctrl[`ILP_B_PHORD];
    end
    next_p0 = route ? s_wave : m_wave;
    next_p1 = ilock ? (route ? m_wave : s_wave) : s_wave;
    next_irq = |(stat & ien);
  end
  always_ff @(posedge CLK_I or negedge rs2) begin
    if (!rs2) begin
      ctrl <= '0;
      phase <= '0;
      ien <= '0;
      stat <= '0;
      rdata <= 32'h0000_0000;
      wait_r <= 1'b1;
      route <= 1'b0;
      p0 <= 1'b0;
      p1 <= 1'b0;
      irq <= 1'b0;
      for (int i = 0; i < 11; i++) begin
        cmp[i] <= `ILP_CNT_ZERO;
      end
    end else begin
      ctrl <= next_ctrl;
      phase <= next_phase;
      ien <= next_ien;
      stat <= next_stat;
      rdata <= next_rdata;
      wait_r <= next_wait;
      route <= next_route;
      p0 <= next_p0;
      p1 <= next_p1;
      irq <= next_irq;
      for (int i = 0; i < 11; i++) begin
        cmp[i] <= next_cmp[i];
      end
    end
  end
  assign AVS_READDATA_O = rdata;
  assign AVS_WAITREQUEST_O = wait_r;
  assign PHASE0_O = p0;
  assign PHASE1_O = p1;
  assign IRQ_O = irq;
endmodule

//--- dv/ilppg_props.sv
`timescale 1ns/1ns
module ilppg_props (
  input wire logic CLK_I, // clock
  input wire logic RST_N_I, // reset
  input wire logic [5:0] AVS_ADDRESS_I, // address
  input wire logic AVS_READ_I, // read
  input wire logic AVS_WRITE_I, // write
  input wire logic [31:0] AVS_WRITEDATA_I, // write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // enables
  input wire logic [31:0] AVS_READDATA_O, // read data
  input wire logic AVS_WAITREQUEST_O, // wait
  input wire logic PHASE0_O, // phase 0
  input wire logic PHASE1_O, // phase 1
  input wire logic IRQ_O // irq
);
  logic ack;
  logic wack;
  logic [3:0] wix;
  logic [7:0] ctrl;
  logic ien0, ien0_q, idle;
  assign ack = !AVS_WAITREQUEST_O;
  assign wack = AVS_WRITE_I && ack;
  assign wix = AVS_ADDRESS_I[5:2];
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= 8'h00;
      ien0 <= 1'b1;
      ien0_q <= 1'b1;
      idle <= 1'b1;
    end else begin
      ien0_q <= ien0;
      if (wack && wix == 4'h0) ctrl <= AVS_WRITEDATA_I[7:0];
      if (wack && wix == 4'h0 && AVS_WRITEDATA_I[1:0] != 2'h0) idle <= 1'b0;
      if (wack && wix == 4'hD) ien0 <= AVS_WRITEDATA_I[9:0] == 10'h000;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_ONE_LOW: assert property (ack |=> !ack) else $error("ack held over two cycles");
  AST_ANSWER: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |=> ack)
    else $error("access not answered in one cycle");
  AST_NO_ACK: assert property (!(AVS_READ_I || AVS_WRITE_I) |=> !ack)
    else $error("ack without request");
  AST_CTRL_BACK: assert property (AVS_READ_I && ack && wix == 4'h0 |->
    AVS_READDATA_O[7:0] == ctrl) else $error("control readback differs");
  AST_ICLR_ZERO: assert property (AVS_READ_I && ack && wix == 4'hE |-> AVS_READDATA_O == 0)
    else $error("clear register read nonzero");
  AST_RD_HOLD: assert property ($changed(AVS_READDATA_O) |-> AVS_READ_I && ack)
    else $error("read data moved outside a read");
  AST_IRQ_MASK: assert property (ien0 && ien0_q |-> !IRQ_O)
    else $error("interrupt with all enables off");
  AST_IDLE_WAVES: assert property (idle |-> !PHASE0_O && !PHASE1_O)
    else $error("wave before any unit ran");
endmodule

//--- dv/ilppg_rx.sv
`timescale 1ns/1ns
module ilppg_rx #(parameter int W = 3) (
  input wire logic clk_i, // clock
  input wire logic p0_i, // first-phase wave
  input wire logic p1_i, // second-phase wave
  output int hi_o, // last high width on p0
  output int lo_o, // last low width on p0
  output int lag_o, // p0 rise to p1 rise
  output int odd_o // high pulses of wrong width
);
  logic q0 = 1'b0;
  logic q1 = 1'b0;
  int c0 = 0;
  int c1 = 0;
  int lc = 0;
  initial begin
    hi_o = 0;
    lo_o = 0;
    lag_o = 0;
    odd_o = 0;
  end
  // widths are whole clocks, so a glitch inside one clock goes unseen
  always @(posedge clk_i) begin
    if (p0_i !== q0) begin
      if (q0 && c0 != W) odd_o++;
      if (q0) hi_o = c0;
      else lo_o = c0;
      if (!q0) lc = 0;
      c0 = 0;
    end
    if (p1_i !== q1) begin
      if (q1 && c1 != W) odd_o++;
      if (!q1) lag_o = lc;
      c1 = 0;
    end
    c0++;
    c1++;
    lc++;
    q0 = p0_i;
    q1 = p1_i;
  end
endmodule

//--- dv/test_ilppg_top.sv
`timescale 1ns/1ns
module test_ilppg_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic wt, p0, p1, irq, il;
  logic [1:0] c;
  logic [31:0] cv [5] = '{32'h0000_0008, 32'h0000_0002, 32'h0000_0005, 32'h0000_0001,
    32'h0000_0006};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int hi, lo, lag, odd, l0, o0;
  always #5 clk = ~clk;
  ilppg_top ilppg_top_i (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wt), .PHASE0_O(p0), .PHASE1_O(p1), .IRQ_O(irq));
  ilppg_rx #(.W(3)) ilppg_rx_i (.clk_i(clk), .p0_i(p0), .p1_i(p1), .hi_o(hi), .lo_o(lo),
    .lag_o(lag), .odd_o(odd));
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= {a, 2'b00};
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input string s, input int e, input logic [31:0] g);
    checks_done++;
    if (g !== 32'(e)) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, 4'h0, 0);
    chk("ctrl reset", 0, q);
    acc(0, 4'hD, 0);
    chk("ien reset", 0, q);
    for (int i = 0; i < 10; i++) acc(1, 4'(i % 5 + 1 + i / 5 * 6), cv[i % 5]);
    acc(1, 4'h6, 32'h0000_0002);
    acc(1, 4'hD, 32'h0000_03FF);
    // every select code in both modes; edges must fire regardless
    for (int m = 0; m < 8; m++) begin
      c = 2'(m % 4);
      il = m > 3;
      acc(1, 4'hE, 32'h0000_03FF);
      acc(1, 4'h0, {24'h00_0000, c, c, 1'b0, il, 2'b11});
      repeat (40) @(posedge clk);
      if (m == 0) chk("high", cv[2] - cv[1], 32'(hi));
      if (m == 0) chk("low", cv[0] - cv[2] + cv[1], 32'(lo));
      acc(1, 4'h0, 0);
      acc(0, 4'hC, 0);
      // the phase compare only runs in interlocked mode
      chk("master cmp0", c == 1 || (c == 2 && il), 32'(q[0]));
      chk("slave cmp0", c == 1 && !il, 32'(q[5]));
      chk("edges", 255, 32'({q[9:6], q[4:1]}));
      chk("irq set", 1, 32'(irq));
    end
    acc(1, 4'hD, 0);
    repeat (3) @(posedge clk);
    chk("irq masked", 0, 32'(irq));
    acc(1, 4'hC, 0);
    acc(0, 4'hC, 0);
    chk("stat kept", 1, 32'(q[1]));
    acc(1, 4'hE, 32'h0000_03FF);
    acc(0, 4'hC, 0);
    chk("stat cleared", 0, q);
    acc(0, 4'hE, 0);
    chk("iclr read", 0, q);
    acc(1, 4'h0, 32'h0000_0005);
    repeat (40) @(posedge clk);
    l0 = lag;
    o0 = odd;
    acc(1, 4'h0, 32'h0000_000D);
    repeat (40) @(posedge clk);
    chk("lag sum", cv[0], 32'(l0 + lag));
    chk("glitches", o0, 32'(odd));
    acc(0, 4'hF, 0);
    chk("route reversed", 1, q);
    acc(1, 4'h0, 32'h0000_0005);
    repeat (40) @(posedge clk);
    chk("lag back", l0, 32'(lag));
    chk("glitches back", o0, 32'(odd));
    acc(0, 4'hF, 0);
    chk("route back", 0, q);
    final_report();
  end
endmodule
bind ilppg_top ilppg_props ilppg_props_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .PHASE0_O(PHASE0_O), .PHASE1_O(PHASE1_O), .IRQ_O(IRQ_O));
